/* File: evc_pkg.sv */
// event channel control package: register map, field layout, reset values, types
// assumes an apb slave with 32-bit data and one clock shared with the generators
// Overview of operation
// - overrun flag sets one cycle after the condition; interrupt if enabled
// - new event while any attached user is not ready is an overrun
// - new event before all users handled the previous one is an overrun
// - asynchronous path never sets the overrun flag
// - writing one clears an overrun flag, zero leaves it
// - writing one to software trigger bit x injects one event on channel x on sync or resync path
// - software trigger register always reads zero
// - twelve channel control words from 0x20, reset value 0x00008000
// - on-request bit 15: clock on while a generator is selected, or only while event handled
// - bit 14 cleared disables channel in standby, set keeps it running
// - edge select 11:10: none, rising, falling, both on sync and resync paths
// - path 9:8: synchronous, resynchronized, asynchronous, one reserved
// - generator select 6:0 picks generator, zero means none connected
// - event seen flag sets a cycle after an event; never on async path
package evc_pkg;

  localparam int EVC_NUM_CH = 12;
  localparam int EVC_GEN_W = 7;

  // register byte offsets
  localparam logic [11:0] EVC_OFS_IEN_CLR = 12'h010;
  localparam logic [11:0] EVC_OFS_IEN_SET = 12'h014;
  localparam logic [11:0] EVC_OFS_FLAGS = 12'h018;
  localparam logic [11:0] EVC_OFS_SOFT_TRIG = 12'h01c;
  localparam logic [11:0] EVC_OFS_CH_BASE = 12'h020;
  localparam logic [11:0] EVC_OFS_CH_LAST = 12'h04c;

  // field positions
  localparam int EVC_OVR_LSB = 0;
  localparam int EVC_SEEN_LSB = 16;
  localparam int EVC_ONREQ_BIT = 15;
  localparam int EVC_ASLEEP_BIT = 14;
  localparam int EVC_EDGE_LSB = 10;
  localparam int EVC_PATH_LSB = 8;
  localparam int EVC_GEN_LSB = 0;

  localparam logic [31:0] EVC_CH_RESET = 32'h0000_8000;
  localparam logic [31:0] EVC_FLAGS_RESET = 32'h0000_0000;
  localparam logic [3:0] EVC_FULL_STRB = 4'hf;
  localparam logic [EVC_GEN_W-1:0] EVC_GEN_NONE = 7'h00;

  typedef enum logic [1:0] {
    EVC_PATH_SYNC = 2'b00,
    EVC_PATH_RESYNC = 2'b01,
    EVC_PATH_ASYNC = 2'b10,
    EVC_PATH_RSVD = 2'b11
  } evc_path_t;

  typedef enum logic [1:0] {
    EVC_EDGE_NONE = 2'b00,
    EVC_EDGE_RISE = 2'b01,
    EVC_EDGE_FALL = 2'b10,
    EVC_EDGE_BOTH = 2'b11
  } evc_edge_t;

  // one channel's configuration as stored
  typedef struct packed {
    logic clockOnRequest;
    logic keepRunningAsleep;
    evc_edge_t edgeSelect;
    evc_path_t path;
    logic [EVC_GEN_W-1:0] generatorSelect;
  } evc_chcfg_t;

  // per-channel status returned to the register block
  typedef struct packed {
    logic overrunHit;
    logic eventSeenHit;
    logic clockRequest;
  } evc_chstat_t;

endpackage : evc_pkg

/* File: evc_channel.sv */
// one event channel: path choice, edge detection, overrun detection
// assumes generator levels on the same clock for the synchronous path
`timescale 1ns/100ps
`default_nettype none
module evc_channel
  import evc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire evc_chcfg_t cfg, // channel configuration
  input wire logic genLevel, // selected generator level
  input wire logic softTrigger, // one-cycle software event
  input wire logic standby, // standby sleep active
  input wire logic usersReady, // all attached users ready
  input wire logic usersDone, // all users handled last event
  output logic eventPulse, // event towards the users
  output logic asyncEvent, // asynchronous path level
  output evc_chstat_t status // hits and clock request
);

  logic genMeta_reg;
  logic genResync_reg;
  logic prevLevel_reg;
  logic pending_reg;
  logic eventPulse_reg;
  logic sampled;
  logic rise;
  logic fall;
  logic edgeHit;
  logic active;
  logic isAsync;
  logic eventNow;

  // channel runs unless in standby without the keep-running bit
  assign active = !standby || cfg.keepRunningAsleep;
  assign isAsync = (cfg.path == EVC_PATH_ASYNC);

  // two-flop resynchroniser for the resynchronized path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      genMeta_reg <= 1'b0;
      genResync_reg <= 1'b0;
    end else begin
      genMeta_reg <= genLevel;
      genResync_reg <= genMeta_reg;
    end
  end

  // pick sampled level by path
  assign sampled = (cfg.path == EVC_PATH_RESYNC) ? genResync_reg : genLevel;

  // previous sample for edge comparison
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prevLevel_reg <= 1'b0;
    end else begin
      prevLevel_reg <= sampled;
    end
  end

  assign rise = sampled && !prevLevel_reg;
  assign fall = !sampled && prevLevel_reg;

  // edge select decode
  always_comb begin
    case (cfg.edgeSelect)
      EVC_EDGE_NONE: edgeHit = 1'b0;
      EVC_EDGE_RISE: edgeHit = rise;
      EVC_EDGE_FALL: edgeHit = fall;
      EVC_EDGE_BOTH: edgeHit = rise || fall;
      default: edgeHit = 1'b0;
    endcase
  end

  // event from edge or software on sync/resync; reserved path gives none, no generator gives no edge event
  assign eventNow = active && !isAsync && (cfg.path != EVC_PATH_RSVD) &&
                    (softTrigger || ((cfg.generatorSelect != EVC_GEN_NONE) && edgeHit));

  // asynchronous path passes the level straight through
  assign asyncEvent = active && isAsync && (cfg.generatorSelect != EVC_GEN_NONE) && genLevel;

  // event pulse to users and pending-handling tracker
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eventPulse_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      eventPulse_reg <= eventNow;
      if (eventNow) begin
        pending_reg <= 1'b1;
      end else if (usersDone) begin
        pending_reg <= 1'b0;
      end
    end
  end

  assign eventPulse = eventPulse_reg;

  // overrun: users not ready or previous event still pending; never async
  assign status.overrunHit = eventNow && (!usersReady || pending_reg);
  assign status.eventSeenHit = eventNow;
  // clock request: always when configured, or only while handling
  assign status.clockRequest = active && (cfg.clockOnRequest ? (eventNow || pending_reg)
                                          : (cfg.generatorSelect != EVC_GEN_NONE));

endmodule : evc_channel
`default_nettype wire

/* File: evc_top.sv */
// event channel control top: apb register block and twelve channels
// assumes apb4 master on clk, generators and users on the same clock
`timescale 1ns/100ps
`default_nettype none
module evc_top
  import evc_pkg::*;
#(
  parameter int NUM_GEN = 128 // generator inputs, index zero unused
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic writeProtect, // access protector lock
  input wire logic standby, // standby sleep active
  input wire logic [NUM_GEN-1:0] genLevels, // generator levels
  input wire logic [EVC_NUM_CH-1:0] usersReady, // all users ready per channel
  input wire logic [EVC_NUM_CH-1:0] usersDone, // all users handled per channel
  output logic [EVC_NUM_CH-1:0] eventPulse, // events towards users
  output logic [EVC_NUM_CH-1:0] asyncEvent, // asynchronous path levels
  output logic [EVC_NUM_CH-1:0] clockRequest, // channel clock requests
  output logic irq // level interrupt
);

  localparam int CH_IDX_W = 4;

  evc_chcfg_t chCfg_reg [EVC_NUM_CH];
  evc_chstat_t chStat [EVC_NUM_CH];
  logic [EVC_NUM_CH-1:0] overrunFlag_reg;
  logic [EVC_NUM_CH-1:0] seenFlag_reg;
  logic [EVC_NUM_CH-1:0] overrunEn_reg;
  logic [EVC_NUM_CH-1:0] seenEn_reg;
  logic [EVC_NUM_CH-1:0] softTrig_reg;
  logic [EVC_NUM_CH-1:0] overrunHit;
  logic [EVC_NUM_CH-1:0] seenHit;
  logic [EVC_NUM_CH-1:0] softTrig_next;
  logic [31:0] prdata_reg;
  logic [31:0] readWord;
  logic setupPhase;
  logic writeDone;
  logic isChannel;
  logic mapped;
  logic [CH_IDX_W-1:0] chIdx;
  logic [11:0] chOfs;

  // pack a stored configuration into its register word
  function automatic logic [31:0] cfgToWord(input evc_chcfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[EVC_ONREQ_BIT] = c.clockOnRequest;
    w[EVC_ASLEEP_BIT] = c.keepRunningAsleep;
    w[EVC_EDGE_LSB +: 2] = c.edgeSelect;
    w[EVC_PATH_LSB +: 2] = c.path;
    w[EVC_GEN_LSB +: EVC_GEN_W] = c.generatorSelect;
    return w;
  endfunction : cfgToWord

  // unpack a register word into a configuration
  function automatic evc_chcfg_t wordToCfg(input logic [31:0] w);
    evc_chcfg_t c;
    c.clockOnRequest = w[EVC_ONREQ_BIT];
    c.keepRunningAsleep = w[EVC_ASLEEP_BIT];
    c.edgeSelect = evc_edge_t'(w[EVC_EDGE_LSB +: 2]);
    c.path = evc_path_t'(w[EVC_PATH_LSB +: 2]);
    c.generatorSelect = w[EVC_GEN_LSB +: EVC_GEN_W];
    return c;
  endfunction : wordToCfg

  // address decode
  assign chOfs = paddr - EVC_OFS_CH_BASE;
  assign chIdx = chOfs[2 +: CH_IDX_W];
  assign isChannel = (paddr >= EVC_OFS_CH_BASE) && (paddr <= EVC_OFS_CH_LAST) &&
                     (paddr[1:0] == 2'b00);
  assign mapped = isChannel || (paddr == EVC_OFS_IEN_CLR) || (paddr == EVC_OFS_IEN_SET) ||
                  (paddr == EVC_OFS_FLAGS) || (paddr == EVC_OFS_SOFT_TRIG);

  // apb phases: zero wait states, writes land at the access edge
  assign setupPhase = psel && !penable;
  assign writeDone = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read mux
  always_comb begin
    readWord = 32'h0000_0000;
    if (isChannel) begin
      readWord = cfgToWord(chCfg_reg[chIdx]);
    end else begin
      case (paddr)
        EVC_OFS_IEN_CLR, EVC_OFS_IEN_SET: begin
          readWord[EVC_OVR_LSB +: EVC_NUM_CH] = overrunEn_reg;
          readWord[EVC_SEEN_LSB +: EVC_NUM_CH] = seenEn_reg;
        end
        EVC_OFS_FLAGS: begin
          readWord[EVC_OVR_LSB +: EVC_NUM_CH] = overrunFlag_reg;
          readWord[EVC_SEEN_LSB +: EVC_NUM_CH] = seenFlag_reg;
        end
        EVC_OFS_SOFT_TRIG: readWord = 32'h0000_0000;
        default: readWord = 32'h0000_0000;
      endcase
    end
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata_reg <= readWord;
    end
  end

  assign prdata = prdata_reg;

  // channel configuration words, full-width unprotected writes only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < EVC_NUM_CH; i++) begin
        chCfg_reg[i] <= wordToCfg(EVC_CH_RESET);
      end
    end else if (writeDone && isChannel && !writeProtect && (pstrb == EVC_FULL_STRB)) begin
      chCfg_reg[chIdx] <= wordToCfg(pwdata);
    end
  end

  // software trigger: one-cycle pulse per written one
  always_comb begin
    softTrig_next = '0;
    if (writeDone && (paddr == EVC_OFS_SOFT_TRIG) && !writeProtect) begin
      softTrig_next = pwdata[EVC_NUM_CH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      softTrig_reg <= '0;
    end else begin
      softTrig_reg <= softTrig_next;
    end
  end

  // interrupt enable pair: set and clear views of one mask
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overrunEn_reg <= '0;
      seenEn_reg <= '0;
    end else if (writeDone && !writeProtect) begin
      if (paddr == EVC_OFS_IEN_SET) begin
        overrunEn_reg <= overrunEn_reg | pwdata[EVC_OVR_LSB +: EVC_NUM_CH];
        seenEn_reg <= seenEn_reg | pwdata[EVC_SEEN_LSB +: EVC_NUM_CH];
      end else if (paddr == EVC_OFS_IEN_CLR) begin
        overrunEn_reg <= overrunEn_reg & ~pwdata[EVC_OVR_LSB +: EVC_NUM_CH];
        seenEn_reg <= seenEn_reg & ~pwdata[EVC_SEEN_LSB +: EVC_NUM_CH];
      end
    end
  end

  // the channels
  genvar g;
  generate
    for (g = 0; g < EVC_NUM_CH; g++) begin : gen_ch
      logic genSel;
      assign genSel = (32'(chCfg_reg[g].generatorSelect) < NUM_GEN) ?
                      genLevels[chCfg_reg[g].generatorSelect] : 1'b0;
      evc_channel u_channel (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg(chCfg_reg[g]),
        .genLevel(genSel),
        .softTrigger(softTrig_reg[g]),
        .standby(standby),
        .usersReady(usersReady[g]),
        .usersDone(usersDone[g]),
        .eventPulse(eventPulse[g]),
        .asyncEvent(asyncEvent[g]),
        .status(chStat[g])
      );
      assign overrunHit[g] = chStat[g].overrunHit;
      assign seenHit[g] = chStat[g].eventSeenHit;
      assign clockRequest[g] = chStat[g].clockRequest;
    end
  endgenerate

  // sticky flags: set next cycle, write one clears, set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overrunFlag_reg <= EVC_FLAGS_RESET[EVC_OVR_LSB +: EVC_NUM_CH];
      seenFlag_reg <= EVC_FLAGS_RESET[EVC_SEEN_LSB +: EVC_NUM_CH];
    end else if (writeDone && (paddr == EVC_OFS_FLAGS)) begin
      overrunFlag_reg <= (overrunFlag_reg & ~pwdata[EVC_OVR_LSB +: EVC_NUM_CH]) | overrunHit;
      seenFlag_reg <= (seenFlag_reg & ~pwdata[EVC_SEEN_LSB +: EVC_NUM_CH]) | seenHit;
    end else begin
      overrunFlag_reg <= overrunFlag_reg | overrunHit;
      seenFlag_reg <= seenFlag_reg | seenHit;
    end
  end

  // one level interrupt from any enabled flag
  assign irq = |(overrunFlag_reg & overrunEn_reg) || |(seenFlag_reg & seenEn_reg);

endmodule : evc_top
`default_nettype wire

/* File: evc_checker.sv */
// port assertions for the event channel control top
// assumes one clock and the apb master of the bench
`timescale 1ns/100ps
`default_nettype none
module evc_checker
  import evc_pkg::*;
#(
  parameter int NUM_GEN = 128 // generator inputs
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [NUM_GEN-1:0] genLevels, // generator levels
  input wire logic [EVC_NUM_CH-1:0] eventPulse, // events out
  input wire logic [EVC_NUM_CH-1:0] clockRequest, // clock requests
  input wire logic irq // interrupt
);
  logic acc;
  logic wrAcc;
  logic [NUM_GEN-1:0] genQ;
  logic [5:0] genHist;
  logic [3:0] trigHist;
  // access phase decode
  assign acc = psel && penable;
  assign wrAcc = acc && pwrite;
  // recent generator changes and trigger writes that may explain an event
  always_ff @(posedge clk) begin
    genQ <= genLevels;
    genHist <= {genHist[4:0], genLevels != genQ};
    trigHist <= {trigHist[2:0], wrAcc && paddr == EVC_OFS_SOFT_TRIG};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ready_always_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  trig_reads_zero_a: assert property (acc && !pwrite && paddr == EVC_OFS_SOFT_TRIG |-> prdata == 32'h0)
    else $error("trigger register read nonzero");
  unmapped_err_a: assert property (acc && paddr > EVC_OFS_CH_LAST |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (acc && paddr >= EVC_OFS_IEN_CLR && paddr <= EVC_OFS_CH_LAST |-> !pslverr)
    else $error("mapped access flagged as error");
  idle_no_err_a: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> eventPulse == '0 && !irq && clockRequest == '0)
    else $error("outputs active after reset");
  event_cause_a: assert property (eventPulse != '0 |-> genHist != 6'h0 || trigHist != 4'h0)
    else $error("event without generator edge or trigger");
  irq_rise_a: assert property ($rose(irq) |-> eventPulse != '0 || $past(wrAcc))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wrAcc))
    else $error("interrupt fell without a write");
endmodule : evc_checker
bind evc_top evc_checker #(.NUM_GEN(NUM_GEN)) chkI (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .genLevels, .eventPulse, .clockRequest, .irq);
`default_nettype wire

/* File: evc_partner.sv */
// event user model: per-channel readiness and completion
// assumes one event pulse per cycle on the shared clock
`timescale 1ns/100ps
`default_nettype none
module evc_partner
  import evc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [EVC_NUM_CH-1:0] eventPulse, // events in
  input wire logic blockUsers, // hold users not ready
  input wire logic slowUsers, // handle events slowly
  output logic [EVC_NUM_CH-1:0] usersReady, // all users ready
  output logic [EVC_NUM_CH-1:0] usersDone // last event handled
);
  logic [2:0] busy_reg [EVC_NUM_CH];
  // handling time, restarted by each event
  always_ff @(posedge clk) begin
    for (int i = 0; i < EVC_NUM_CH; i++) begin
      if (sys_rst) busy_reg[i] <= 3'h0;
      else if (eventPulse[i]) busy_reg[i] <= slowUsers ? 3'h6 : 3'h1;
      else if (busy_reg[i] != 3'h0) busy_reg[i] <= busy_reg[i] - 3'h1;
    end
  end
  // done in the last cycle of handling
  always_comb begin
    for (int i = 0; i < EVC_NUM_CH; i++) begin
      usersDone[i] = busy_reg[i] == 3'h1;
      usersReady[i] = !blockUsers;
    end
  end
endmodule : evc_partner
`default_nettype wire

/* File: test_event_channel_control.sv */
// self-checking bench for the event channel control block
// assumes evc_partner as the users and the bound checker
`timescale 1ns/100ps
`default_nettype none
module test_event_channel_control;
  import evc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic writeProtect = 1'b0;
  logic standby = 1'b0;
  logic blockUsers = 1'b0;
  logic slowUsers = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [127:0] genLevels = '0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, irq, err;
  logic [11:0] usersReady, usersDone, eventPulse, asyncEvent, clockRequest;
  int failures = 0;
  int cmp_count = 0;
  int pc = 0;
  int cyc = 0;
  int ex, nx;
  always #5 clk = ~clk;
  evc_top DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .writeProtect, .standby, .genLevels, .usersReady, .usersDone, .eventPulse, .asyncEvent, .clockRequest, .irq);
  evc_partner PRT (.clk, .sys_rst, .eventPulse, .blockUsers, .slowUsers, .usersReady, .usersDone);
  // counts channel 0 events and cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (eventPulse[0] === 1'b1) pc <= pc + 1;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one apb transfer, strobes as given by the caller
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task results;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // main sequence
  initial begin
    tk(8);
    sys_rst <= 1'b0;
    for (int n = 0; n < 12; n++) begin
      apb(1'b0, EVC_OFS_CH_BASE + 12'(4 * n), 32'h0, 4'h0);
      chk("channel reset", rdata, EVC_CH_RESET);
    end
    apb(1'b0, 12'h0fc, 32'h0, 4'h0);
    chk("unmapped error", 32'(err), 32'h1);
    $display("test reset done");
    apb(1'b1, EVC_OFS_SOFT_TRIG, 32'h0, 4'hf);
    tk(4);
    chk("zero trigger", 32'(pc), 32'h0);
    apb(1'b1, EVC_OFS_SOFT_TRIG, 32'h0000_0fff, 4'hf);
    ex = 0;
    while (eventPulse === 12'h000 && ex < 6) begin
      tk(1);
      ex++;
    end
    chk("all triggers", 32'(eventPulse), 32'h0000_0fff);
    apb(1'b0, EVC_OFS_SOFT_TRIG, 32'h0, 4'h0);
    chk("trigger read", rdata, 32'h0);
    apb(1'b1, EVC_OFS_FLAGS, 32'h0, 4'hf);
    apb(1'b0, EVC_OFS_FLAGS, 32'h0, 4'h0);
    chk("flags kept", rdata, 32'h0fff_0000);
    apb(1'b1, EVC_OFS_FLAGS, 32'hffff_ffff, 4'hf);
    apb(1'b0, EVC_OFS_FLAGS, 32'h0, 4'h0);
    chk("flags cleared", rdata, 32'h0);
    $display("test trigger done");
    writeProtect <= 1'b1;
    ex = pc;
    apb(1'b1, EVC_OFS_CH_BASE, 32'h0, 4'hf);
    apb(1'b1, EVC_OFS_SOFT_TRIG, 32'h1, 4'hf);
    tk(4);
    chk("protected trigger", 32'(pc - ex), 32'h0);
    writeProtect <= 1'b0;
    apb(1'b1, EVC_OFS_CH_BASE, 32'h0, 4'h3);
    apb(1'b0, EVC_OFS_CH_BASE, 32'h0, 4'h0);
    chk("protected or partial", rdata, EVC_CH_RESET);
    $display("test protect done");
    apb(1'b1, 12'h030, 32'h0000_0003, 4'hf);
    tk(1);
    chk("clock always on", 32'(clockRequest[4]), 32'h1);
    standby <= 1'b1;
    tk(1);
    chk("standby off", 32'(clockRequest[4]), 32'h0);
    apb(1'b1, 12'h030, 32'h0000_4003, 4'hf);
    tk(1);
    chk("standby running", 32'(clockRequest[4]), 32'h1);
    apb(1'b1, 12'h030, 32'h0000_4000, 4'hf);
    tk(1);
    chk("no generator", 32'(clockRequest[4]), 32'h0);
    standby <= 1'b0;
    $display("test clock done");
    apb(1'b1, EVC_OFS_IEN_SET, 32'h0001_0001, 4'hf);
    blockUsers <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 4; e++) begin
        if (p > 1 && e > 0) continue;
        apb(1'b1, EVC_OFS_CH_BASE, 32'h8005 | 32'(e) << 10 | 32'(p) << 8, 4'hf);
        ex = pc;
        genLevels[5] <= 1'b1;
        tk(6);
        if (p == 2) chk("async level", 32'(asyncEvent[0]), 32'h1);
        genLevels[5] <= 1'b0;
        tk(6);
        nx = (p > 1 || e == 0) ? 0 : (e == 3 ? 2 : 1);
        chk("edge count", 32'(pc - ex), 32'(nx));
        apb(1'b0, EVC_OFS_FLAGS, 32'h0, 4'h0);
        chk("overrun and seen", rdata, nx > 0 ? 32'h0001_0001 : 32'h0);
        chk("irq level", 32'(irq), 32'(nx > 0));
        apb(1'b1, EVC_OFS_FLAGS, 32'hffff_ffff, 4'hf);
      end
    end
    blockUsers <= 1'b0;
    $display("test paths done");
    slowUsers <= 1'b1;
    apb(1'b1, EVC_OFS_SOFT_TRIG, 32'h2, 4'hf);
    apb(1'b1, EVC_OFS_SOFT_TRIG, 32'h2, 4'hf);
    tk(4);
    chk("request while busy", 32'(clockRequest[1]), 32'h1);
    apb(1'b0, EVC_OFS_FLAGS, 32'h0, 4'h0);
    chk("pending overrun", rdata, 32'h0002_0002);
    tk(6);
    chk("request released", 32'(clockRequest[1]), 32'h0);
    $display("test pending done");
    // enable pair: set and clear views share one mask
    apb(1'b0, EVC_OFS_IEN_SET, 32'h0, 4'h0);
    chk("enable set view", rdata, 32'h0001_0001);
    apb(1'b1, EVC_OFS_IEN_CLR, 32'h0000_0001, 4'hf);
    apb(1'b0, EVC_OFS_IEN_CLR, 32'h0, 4'h0);
    chk("enable clear view", rdata, 32'h0001_0000);
    $display("test enable done");
    results();
  end
endmodule : test_event_channel_control
`default_nettype wire
